// file: logic/dcm_mode_logic.sv
// contact inputs to governor modes, load ramp targets and reference commands
`timescale 1ns/1ps
// Summary of operation
// - Breaker-auxiliary true selects isochronous with load control; false selects droop.
// - Base-load true runs base-load operation and disables load sharing.
// - Base-load false allows load sharing once unit loading is matched.
// - Base-load and load-generator are ignored unless breaker-auxiliary is true.
// - Load-generator true ramps load target toward sharing or base load.
// - Load-generator false ramps to unload trip, then one breaker-open pulse.
// - Alarm-clear option gives the multi-function contact the alarm-clear role.
// - Otherwise contact serves second load ramp, else second dynamics, else nothing.
// - Second dynamics from contact alone, from breaker-aux when combined, else none.
// - Raise steps speed reference in droop/iso, baseload reference in base.
// - Speed raising stops at the raise-speed (maximum) limit.
// - Baseload reference rises at set rates, capped at rated load.
// - Raise released: reference stops rising and holds.
// - Lower steps speed reference in droop/iso, baseload reference in base.
// - Lowering stops at lower-speed limit or unload trip, at set rate.
// - Lower released: reference stops falling and holds.
// - Raise and lower held together enable the remote reference.
// - Remote reference goes to speed or baseload per current mode.
// - Rated-speed deselected: raise and lower are disregarded.
// - In droop, raise lifts fuel demand and load through speed reference.
// - Rated true ramps speed to rated over accel; false to idle.
module dcm_mode_logic #(
    parameter int unsigned REF_W = dcm_pkg::REF_W_DEF,
    parameter int unsigned DEB_CYC = dcm_pkg::DEB_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_breaker_auxiliary_input,
    input wire logic i_base_load_input,
    input wire logic i_load_gen_input,
    input wire logic i_multi_contact_input,
    input wire logic i_raise_input,
    input wire logic i_lower_input,
    input wire logic i_rated_speed_input,
    input wire logic i_contact_as_alarm_clear_option,
    input wire logic i_alternate_dynamics_option,
    input wire logic i_contact_as_second_ramp_option,
    input wire logic i_load_matched,
    input wire logic [REF_W-1:0] i_raise_speed_limit,
    input wire logic [REF_W-1:0] i_lower_speed_limit,
    input wire logic [REF_W-1:0] i_rated_speed_point,
    input wire logic [REF_W-1:0] i_idle_speed_point,
    input wire logic [REF_W-1:0] i_accel_step,
    input wire logic [REF_W-1:0] i_decel_step,
    input wire logic [REF_W-1:0] i_speed_raise_rate,
    input wire logic [REF_W-1:0] i_lower_rate,
    input wire logic [REF_W-1:0] i_base_raise_rate,
    input wire logic [REF_W-1:0] i_rated_load_limit,
    input wire logic [REF_W-1:0] i_unload_trip_level,
    input wire logic [REF_W-1:0] i_share_load_target,
    input wire logic [REF_W-1:0] i_load_ramp_rate,
    input wire logic [REF_W-1:0] i_second_load_ramp_rate,
    input wire logic [REF_W-1:0] i_remote_ref,
    output dcm_pkg::dcm_mode_type o_mode,
    output dcm_pkg::dcm_cfunc_type o_contact_func,
    output logic o_load_share_en,
    output logic o_breaker_open,
    output logic o_second_dynamics,
    output logic o_alarm_clear,
    output logic o_second_ramp_sel,
    output logic o_speed_raise,
    output logic o_speed_lower,
    output logic o_base_raise,
    output logic o_base_lower,
    output logic o_remote_ref_en,
    output logic o_remote_to_base,
    output logic [REF_W-1:0] o_speed_ref,
    output logic [REF_W-1:0] o_base_ref,
    output logic [REF_W-1:0] o_load_target
);
    import dcm_pkg::*;

    // refused at elaboration, before any logic is built
    if (REF_W < 8 || REF_W > 16 || DEB_CYC < 1) begin : g_bad_param
        $error("dcm_mode_logic: REF_W must be 8 to 16 and DEB_CYC at least 1");
    end

    logic [NUM_CONTACTS-1:0] raw;
    logic [NUM_CONTACTS-1:0] db;
    logic brk;
    logic base_in;
    logic ldgen;
    logic cont_d;
    logic raise_in;
    logic lower_in;
    logic rated;

    assign raw = {i_rated_speed_input, i_lower_input, i_raise_input, i_multi_contact_input,
                  i_load_gen_input, i_base_load_input, i_breaker_auxiliary_input};

    dcm_debounce #(
        .N(NUM_CONTACTS),
        .CYC(DEB_CYC)
    ) u_deb (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_raw(raw),
        .o_clean(db)
    );

    assign brk = db[CT_BRK_AUX];
    assign base_in = db[CT_BASE_LOAD];
    assign ldgen = db[CT_LOAD_GEN];
    assign cont_d = db[CT_MULTI];
    assign raise_in = db[CT_RAISE];
    assign lower_in = db[CT_LOWER];
    assign rated = db[CT_RATED];

    // mode selection
    dcm_mode_type mode_r;
    dcm_mode_type mode_nxt;
    logic base_mode;

    always_comb begin
        if (!brk) begin
            mode_nxt = MODE_DROOP;
        end else if (base_in) begin
            mode_nxt = MODE_BASE;
        end else begin
            mode_nxt = MODE_ISO;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r <= MODE_DROOP;
            o_load_share_en <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            o_load_share_en <= brk && !base_in && i_load_matched;
        end
    end

    assign o_mode = mode_r;
    assign base_mode = (mode_r == MODE_BASE);

    // multi-function contact role
    function automatic dcm_cfunc_type contact_role(input logic clr, input logic alt,
                                                   input logic ramp2);
        if (clr) begin
            contact_role = CFN_ALARM_CLEAR;
        end else if (ramp2) begin
            contact_role = CFN_SECOND_RAMP;
        end else if (alt) begin
            contact_role = CFN_ALT_DYN;
        end else begin
            contact_role = CFN_NONE;
        end
    endfunction : contact_role

    dcm_cfunc_type cfunc;
    logic dyn_nxt;

    assign cfunc = contact_role(i_contact_as_alarm_clear_option, i_alternate_dynamics_option,
                                i_contact_as_second_ramp_option);

    always_comb begin
        if (!i_alternate_dynamics_option) begin
            dyn_nxt = 1'b0;
        end else if (i_contact_as_alarm_clear_option || i_contact_as_second_ramp_option) begin
            dyn_nxt = brk;
        end else begin
            dyn_nxt = cont_d;
        end
    end

    // alarm clear is a level, held as long as the contact stays closed
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_contact_func <= CFN_NONE;
            o_second_dynamics <= 1'b0;
            o_alarm_clear <= 1'b0;
            o_second_ramp_sel <= 1'b0;
        end else begin
            o_contact_func <= cfunc;
            o_second_dynamics <= dyn_nxt;
            o_alarm_clear <= (cfunc == CFN_ALARM_CLEAR) && cont_d;
            o_second_ramp_sel <= (cfunc == CFN_SECOND_RAMP) && cont_d;
        end
    end

    // raise/lower/remote decode, all gated by rated speed
    logic remote_en;
    logic raise_cmd;
    logic lower_cmd;

    assign remote_en = rated && raise_in && lower_in;
    assign raise_cmd = rated && raise_in && !lower_in;
    assign lower_cmd = rated && lower_in && !raise_in;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_speed_raise <= 1'b0;
            o_speed_lower <= 1'b0;
            o_base_raise <= 1'b0;
            o_base_lower <= 1'b0;
            o_remote_ref_en <= 1'b0;
            o_remote_to_base <= 1'b0;
        end else begin
            o_speed_raise <= raise_cmd && !base_mode;
            o_speed_lower <= lower_cmd && !base_mode;
            o_base_raise <= raise_cmd && base_mode;
            o_base_lower <= lower_cmd && base_mode;
            o_remote_ref_en <= remote_en;
            o_remote_to_base <= remote_en && base_mode;
        end
    end

    // speed reference
    dcm_ramp_if #(.W(REF_W)) spd_if ();
    logic at_rated_r;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            at_rated_r <= 1'b0;
        end else if (!rated) begin
            at_rated_r <= 1'b0;
        end else if (spd_if.value == i_rated_speed_point) begin
            at_rated_r <= 1'b1;
        end
    end

    always_comb begin
        spd_if.up = 1'b0;
        spd_if.down = 1'b0;
        spd_if.load = 1'b0;
        spd_if.step = '0;
        spd_if.lo = i_lower_speed_limit;
        spd_if.hi = i_raise_speed_limit;
        spd_if.load_val = i_remote_ref;
        if (!rated) begin
            spd_if.lo = i_idle_speed_point;
            spd_if.hi = i_idle_speed_point;
            spd_if.up = spd_if.value < i_idle_speed_point;
            spd_if.down = spd_if.value > i_idle_speed_point;
            spd_if.step = spd_if.down ? i_decel_step : i_accel_step;
        end else if (!at_rated_r) begin
            spd_if.lo = i_rated_speed_point;
            spd_if.hi = i_rated_speed_point;
            spd_if.up = spd_if.value < i_rated_speed_point;
            spd_if.down = spd_if.value > i_rated_speed_point;
            spd_if.step = spd_if.up ? i_accel_step : i_decel_step;
        end else if (!base_mode) begin
            spd_if.load = remote_en;
            spd_if.up = raise_cmd;
            spd_if.down = lower_cmd;
            spd_if.step = raise_cmd ? i_speed_raise_rate : i_lower_rate;
        end
    end

    dcm_ramp #(.W(REF_W)) u_spd (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .rp(spd_if.ramp)
    );

    // baseload reference
    dcm_ramp_if #(.W(REF_W)) base_if ();

    always_comb begin
        base_if.lo = i_unload_trip_level;
        base_if.hi = i_rated_load_limit;
        base_if.load_val = i_remote_ref;
        base_if.load = remote_en && base_mode;
        base_if.up = raise_cmd && base_mode;
        base_if.down = lower_cmd && base_mode;
        base_if.step = base_if.up ? i_base_raise_rate : i_lower_rate;
    end

    dcm_ramp #(.W(REF_W)) u_base (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .rp(base_if.ramp)
    );

    // load control target
    dcm_ramp_if #(.W(REF_W)) load_if ();
    logic [REF_W-1:0] load_goal;
    logic unloading;
    logic opened_r;
    logic open_nxt;

    assign unloading = brk && !ldgen;
    assign load_goal = !ldgen ? i_unload_trip_level :
                       (base_mode ? base_if.value : i_share_load_target);

    always_comb begin
        load_if.lo = load_goal;
        load_if.hi = load_goal;
        load_if.load_val = i_unload_trip_level;
        // in droop the target parks at the unload level so a later close starts low
        load_if.load = !brk;
        load_if.up = brk && (load_if.value < load_goal);
        load_if.down = brk && (load_if.value > load_goal);
        load_if.step = o_second_ramp_sel ? i_second_load_ramp_rate : i_load_ramp_rate;
    end

    dcm_ramp #(.W(REF_W)) u_load (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .rp(load_if.ramp)
    );

    assign open_nxt = unloading && !opened_r && (load_if.value <= i_unload_trip_level);

    // latch prevents a repeat pulse while the target rests at the trip level
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            opened_r <= 1'b0;
            o_breaker_open <= 1'b0;
        end else begin
            opened_r <= unloading && (opened_r || open_nxt);
            o_breaker_open <= open_nxt;
        end
    end

    assign o_speed_ref = spd_if.value;
    assign o_base_ref = base_if.value;
    assign o_load_target = load_if.value;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    property p_iso_when_closed;
        brk |=> (mode_r != MODE_DROOP);
    endproperty
    a_iso_when_closed: assert property (p_iso_when_closed)
        else $error("breaker aux closed but mode is droop");

    property p_droop_when_open;
        !brk |=> (mode_r == MODE_DROOP) && !o_load_share_en;
    endproperty
    a_droop_when_open: assert property (p_droop_when_open)
        else $error("breaker aux open but mode not droop");

    property p_base_no_share;
        (mode_r == MODE_BASE) |-> !o_load_share_en;
    endproperty
    a_base_no_share: assert property (p_base_no_share)
        else $error("load sharing enabled in base load");

    property p_no_open_in_droop;
        !brk |=> !o_breaker_open;
    endproperty
    a_no_open_in_droop: assert property (p_no_open_in_droop)
        else $error("breaker open pulse without breaker aux");

    property p_open_single;
        o_breaker_open |-> (o_load_target <= i_unload_trip_level) ##1 !o_breaker_open [*3];
    endproperty
    a_open_single: assert property (p_open_single)
        else $error("breaker open pulse not single or above trip level");

    property p_clear_role;
        (i_contact_as_alarm_clear_option && cont_d) |=> o_alarm_clear && !o_second_ramp_sel;
    endproperty
    a_clear_role: assert property (p_clear_role)
        else $error("alarm clear role not taken");

    property p_dyn_from_contact;
        (i_alternate_dynamics_option && !i_contact_as_alarm_clear_option
         && !i_contact_as_second_ramp_option) |=> (o_second_dynamics == $past(cont_d));
    endproperty
    a_dyn_from_contact: assert property (p_dyn_from_contact)
        else $error("second dynamics not from contact");

    property p_remote_enable;
        (rated && raise_in && lower_in) |=> o_remote_ref_en && !o_speed_raise && !o_base_lower;
    endproperty
    a_remote_enable: assert property (p_remote_enable)
        else $error("remote reference not enabled");

    property p_rated_gate;
        !rated |=> !(o_speed_raise || o_speed_lower || o_base_raise || o_base_lower
                     || o_remote_ref_en);
    endproperty
    a_rated_gate: assert property (p_rated_gate)
        else $error("raise or lower acted without rated speed");

    c_breaker_open: cover property (o_breaker_open);
    c_remote_base: cover property (o_remote_ref_en && o_remote_to_base);
    c_base_raise: cover property (o_base_raise ##1 o_base_raise);
    c_iso_share: cover property (mode_r == MODE_ISO && o_load_share_en);
endmodule : dcm_mode_logic

// file: logic/dcm_pkg.sv
// shared constants and types for the discrete command and mode logic
package dcm_pkg;

    localparam int unsigned CLK_FREQ_HZ = 25_000_000;
    // least contact-stable time before a change is accepted
    localparam int unsigned DEB_TIME_US = 5_000;
    localparam int unsigned DEB_CYCLES_CALC =
        int'((64'(DEB_TIME_US) * 64'(CLK_FREQ_HZ) + 64'd999_999) / 64'd1_000_000);
    localparam int unsigned DEB_CYCLES = (DEB_CYCLES_CALC < 1) ? 1 : DEB_CYCLES_CALC;

    localparam int unsigned REF_W_DEF = 16;
    localparam int unsigned NUM_CONTACTS = 7;

    // bit positions of the discrete contacts in the debounced vector
    localparam int unsigned CT_BRK_AUX = 0;
    localparam int unsigned CT_BASE_LOAD = 1;
    localparam int unsigned CT_LOAD_GEN = 2;
    localparam int unsigned CT_MULTI = 3;
    localparam int unsigned CT_RAISE = 4;
    localparam int unsigned CT_LOWER = 5;
    localparam int unsigned CT_RATED = 6;

    localparam logic [15:0] REF_RESET_VAL = 16'h0000;

    typedef enum logic [2:0] {
        MODE_DROOP = 3'b001,
        MODE_ISO = 3'b010,
        MODE_BASE = 3'b100
    } dcm_mode_type;

    typedef enum logic [3:0] {
        CFN_NONE = 4'b0001,
        CFN_ALT_DYN = 4'b0010,
        CFN_SECOND_RAMP = 4'b0100,
        CFN_ALARM_CLEAR = 4'b1000
    } dcm_cfunc_type;

endpackage : dcm_pkg

// file: logic/dcm_ramp_if.sv
// command bundle between the mode logic and one reference ramp
`timescale 1ns/1ps
interface dcm_ramp_if #(
    parameter int unsigned W = 16
);
    logic up;
    logic down;
    logic load;
    logic [W-1:0] step;
    logic [W-1:0] lo;
    logic [W-1:0] hi;
    logic [W-1:0] load_val;
    logic [W-1:0] value;

    modport ctrl (output up, down, load, step, lo, hi, load_val, input value);
    modport ramp (input up, down, load, step, lo, hi, load_val, output value);
endinterface : dcm_ramp_if

// file: logic/dcm_debounce.sv
// two-flop synchroniser and stable-time filter for each contact
`timescale 1ns/1ps
module dcm_debounce #(
    parameter int unsigned N = 7,
    parameter int unsigned CYC = 125_000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [N-1:0] i_raw,
    output logic [N-1:0] o_clean
);
    import dcm_pkg::*;

    localparam int unsigned CW = $clog2(CYC + 1);

    // refused at elaboration, before any logic is built
    if (N < 1 || CYC < 1) begin : g_bad_param
        $error("dcm_debounce: N and CYC must be at least 1");
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            logic meta_r;
            logic sync_r;
            logic [CW-1:0] cnt_r;
            // first flop feeds only the second
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= i_raw[g];
                    sync_r <= meta_r;
                end
            end
            // any bounce restarts the count, so a chattering contact never flips
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    cnt_r <= '0;
                    o_clean[g] <= 1'b0;
                end else if (sync_r == o_clean[g]) begin
                    cnt_r <= '0;
                end else if (cnt_r == CW'(CYC - 1)) begin
                    cnt_r <= '0;
                    o_clean[g] <= sync_r;
                end else begin
                    cnt_r <= cnt_r + CW'(1);
                end
            end
        end
    endgenerate
endmodule : dcm_debounce

// file: logic/dcm_ramp.sv
// one reference ramp: bounded step up or down, hold, or direct load
`timescale 1ns/1ps
module dcm_ramp #(
    parameter int unsigned W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    dcm_ramp_if.ramp rp
);
    import dcm_pkg::*;

    logic [W-1:0] value_r;
    logic [W-1:0] value_nxt;
    logic [W:0] sum;

    // refused at elaboration, before any logic is built
    if (W < 8 || W > 16) begin : g_bad_param
        $error("dcm_ramp: W must be 8 to 16");
    end

    always_comb begin
        sum = {1'b0, value_r} + {1'b0, rp.step};
        value_nxt = value_r;
        if (rp.load) begin
            value_nxt = rp.load_val;
        end else if (rp.up && value_r < rp.hi) begin
            value_nxt = (sum > {1'b0, rp.hi}) ? rp.hi : sum[W-1:0];
        end else if (rp.down && value_r > rp.lo) begin
            value_nxt = ((value_r - rp.lo) < rp.step) ? rp.lo : value_r - rp.step;
        end
    end

    // no command means the value simply stays
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            value_r <= REF_RESET_VAL[W-1:0];
        end else begin
            value_r <= value_nxt;
        end
    end

    assign rp.value = value_r;

    property p_hold_idle;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!rp.up && !rp.down && !rp.load) |=> (value_r == $past(value_r));
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("ramp moved with no command");
endmodule : dcm_ramp

// file: testbench/dcm_contacts.sv
// switch and relay contact model for the discrete inputs
`timescale 1ns/1ps
module dcm_contacts (
    input wire logic i_ref_clk,
    input wire logic [6:0] i_cmd,
    input wire logic [6:0] i_chat,
    output logic [6:0] o_raw
);
    logic [6:0] ph_r = 7'h00;
    // chatter flips each cycle, shorter than the four-cycle debounce window of the bench
    always @(posedge i_ref_clk) begin
        ph_r <= ~ph_r & i_chat;
    end
    assign o_raw = i_cmd ^ ph_r;
endmodule : dcm_contacts

// file: testbench/dcm_mode_logic_tb.sv
// self-checking bench for the discrete command and mode logic
`timescale 1ns/1ps
module dcm_mode_logic_tb;
    import dcm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] cmd = 7'h00;
    logic [6:0] chat = 7'h00;
    logic [6:0] raw;
    logic ca = 1'b0, ad = 1'b0, sr = 1'b0, lm = 1'b1;
    logic [15:0] rsl = 16'h0150, lsl = 16'h00c0, rpt = 16'h0100, idl = 16'h0080;
    logic [15:0] stp = 16'h0040, srr = 16'h0004, lwr = 16'h0010, brr = 16'h0020;
    logic [15:0] rll = 16'h0200, utl = 16'h0040, slt = 16'h0180, lrr = 16'h0020;
    logic [15:0] rem = 16'h0123, dcl = 16'h0020;
    dcm_mode_type mode;
    dcm_cfunc_type cf;
    logic lse, bo, sd, ac, srs, spr, spl, bsr, bsl, ren, rtb;
    logic [15:0] spd, bas, ltg;
    int errors = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    dcm_contacts sw (.i_ref_clk(clk), .i_cmd(cmd), .i_chat(chat), .o_raw(raw));
    dcm_mode_logic #(.REF_W(16), .DEB_CYC(4)) uut (
        .i_ref_clk(clk), .i_rst(rst), .i_breaker_auxiliary_input(raw[CT_BRK_AUX]),
        .i_base_load_input(raw[CT_BASE_LOAD]), .i_load_gen_input(raw[CT_LOAD_GEN]),
        .i_multi_contact_input(raw[CT_MULTI]), .i_raise_input(raw[CT_RAISE]),
        .i_lower_input(raw[CT_LOWER]), .i_rated_speed_input(raw[CT_RATED]),
        .i_contact_as_alarm_clear_option(ca), .i_alternate_dynamics_option(ad),
        .i_contact_as_second_ramp_option(sr), .i_load_matched(lm),
        .i_raise_speed_limit(rsl), .i_lower_speed_limit(lsl), .i_rated_speed_point(rpt),
        .i_idle_speed_point(idl), .i_accel_step(stp), .i_decel_step(dcl),
        .i_speed_raise_rate(srr), .i_lower_rate(lwr), .i_base_raise_rate(brr),
        .i_rated_load_limit(rll), .i_unload_trip_level(utl), .i_share_load_target(slt),
        .i_load_ramp_rate(lrr), .i_second_load_ramp_rate(stp), .i_remote_ref(rem),
        .o_mode(mode), .o_contact_func(cf), .o_load_share_en(lse), .o_breaker_open(bo),
        .o_second_dynamics(sd), .o_alarm_clear(ac), .o_second_ramp_sel(srs),
        .o_speed_raise(spr), .o_speed_lower(spl), .o_base_raise(bsr), .o_base_lower(bsl),
        .o_remote_ref_en(ren), .o_remote_to_base(rtb), .o_speed_ref(spd),
        .o_base_ref(bas), .o_load_target(ltg));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // 12 covers sync, debounce and output register with margin
    task automatic set(input int b, input logic v);
        cmd[b] = v;
        cyc(12);
    endtask : set
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic t_bounce();
        chat[CT_BRK_AUX] = 1'b1;
        repeat (20) begin
            cyc(1);
            chk(16'(mode), 16'(MODE_DROOP));
        end
        chat[CT_BRK_AUX] = 1'b0;
    endtask : t_bounce
    task automatic t_speed();
        logic [15:0] a;
        set(CT_RATED, 1'b1);
        chk(spd, rpt);
        set(CT_RAISE, 1'b1);
        chk(16'(spr), 16'h0001);
        a = spd;
        cyc(1);
        chk(spd - a, srr);
        set(CT_RAISE, 1'b0);
        a = spd;
        chk(16'(a < rsl), 16'h0001);
        cyc(5);
        chk(spd, a);
        set(CT_RAISE, 1'b1);
        cyc(30);
        chk(spd, rsl);
        cmd[CT_RAISE] = 1'b0;
        set(CT_LOWER, 1'b1);
        chk(16'(spl), 16'h0001);
        cyc(10);
        chk(spd, lsl);
        set(CT_LOWER, 1'b0);
        chk(spd, lsl);
    endtask : t_speed
    task automatic t_remote(input logic b);
        cmd[CT_RAISE] = 1'b1;
        set(CT_LOWER, 1'b1);
        chk(16'(ren), 16'h0001);
        chk(16'(rtb), 16'(b));
        chk(b ? bas : spd, rem);
        cmd[CT_RAISE] = 1'b0;
        set(CT_LOWER, 1'b0);
    endtask : t_remote
    task automatic t_rated_off();
        logic [15:0] a;
        cmd[CT_RATED] = 1'b0;
        cmd[CT_RAISE] = 1'b1;
        cyc(7);
        a = spd;
        cyc(1);
        chk(a - spd, dcl);
        cyc(22);
        chk(spd, idl);
        chk(16'(spr), 16'h0000);
        cmd[CT_RAISE] = 1'b0;
        set(CT_RATED, 1'b1);
    endtask : t_rated_off
    task automatic t_modes();
        cmd[CT_BASE_LOAD] = 1'b1;
        set(CT_LOAD_GEN, 1'b1);
        chk(16'(mode), 16'(MODE_DROOP));
        chk(ltg, utl);
        cmd[CT_BASE_LOAD] = 1'b0;
        set(CT_BRK_AUX, 1'b1);
        chk(16'(mode), 16'(MODE_ISO));
        chk(16'(lse), 16'h0001);
        lm = 1'b0;
        cyc(2);
        chk(16'(lse), 16'h0000);
        lm = 1'b1;
        set(CT_BASE_LOAD, 1'b1);
        chk(16'(mode), 16'(MODE_BASE));
        chk(16'(lse), 16'h0000);
    endtask : t_modes
    task automatic t_base();
        set(CT_RAISE, 1'b1);
        chk(16'(bsr), 16'h0001);
        cyc(30);
        chk(bas, rll);
        set(CT_RAISE, 1'b0);
        set(CT_LOWER, 1'b1);
        chk(16'(bsl), 16'h0001);
        cyc(30);
        chk(bas, utl);
        set(CT_LOWER, 1'b0);
        t_remote(1'b1);
    endtask : t_base
    task automatic t_cfunc();
        dcm_cfunc_type f;
        for (int p = 0; p < 2; p++) begin
            cmd[CT_MULTI] = (p == 0);
            set(CT_BRK_AUX, p == 1);
            for (int i = 0; i < 8; i++) begin
                {ca, ad, sr} = 3'(i);
                cyc(3);
                f = ca ? CFN_ALARM_CLEAR : sr ? CFN_SECOND_RAMP : ad ? CFN_ALT_DYN : CFN_NONE;
                chk(16'(cf), 16'(f));
                chk(16'(sd), 16'(ad && ((ca || sr) == (p == 1))));
                chk(16'(ac), 16'(ca && p == 0));
                chk(16'(srs), 16'(sr && !ca && p == 0));
            end
        end
        {ca, ad, sr} = 3'b000;
    endtask : t_cfunc
    task automatic t_unload();
        int n;
        logic [15:0] a;
        n = 0;
        sr = 1'b1;
        cmd[CT_MULTI] = 1'b1;
        set(CT_BASE_LOAD, 1'b0);
        cyc(12);
        chk(ltg, slt);
        cmd[CT_LOAD_GEN] = 1'b0;
        cyc(7);
        a = ltg;
        cyc(1);
        chk(a - ltg, stp);
        repeat (22) begin
            cyc(1);
            if (bo === 1'b1) n++;
        end
        chk(16'(n), 16'h0001);
        chk(ltg, utl);
    endtask : t_unload
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(16'(mode), 16'(MODE_DROOP));
        t_bounce();
        t_speed();
        t_remote(1'b0);
        t_rated_off();
        t_modes();
        t_base();
        t_cfunc();
        t_unload();
        summarize();
    end
    // a hang ends the run with one counted mismatch
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule : dcm_mode_logic_tb
